// file: hdl/fst_consts.vh
// Function
// - Status word goes out on the TDM line only while the transmit enable is set
// - A six-bit field picks the slot; host keeps that slot free of other talkers
// - Status byte: powered, low supply, gate, limiter, brownout, hot, overcurrent, UV
// - Hot, overcurrent and UV bits only in shutdown transient; nothing after shutdown
// - Four die temperature warnings at four rising thresholds
// - Temperature warnings read live at 0x47 and latched at 0x4F on page 0
// - Five-bit field enables weak pull-downs on audio inputs and inter-chip input
// - Pull-downs stay off during hardware shutdown regardless of the field
// - Pull-down enable field lives at page-0 offset 0x38
// - Live flags at 0x42-0x44, 0x47, 0x48; masks at 0x3B-0x3D, 0x40, 0x41
// - Latched flags at 0x49-0x4B and 0x4F-0x51
// - Clock settings and interrupt pin setup share offset 0x5C
// - Live flags clear on shutdown; latched flags survive it
// - Open-drain interrupt pulls low while any unmasked latched flag is set
// - Writing the latch clear bit clears at once every latched flag whose condition has gone
`ifndef FST_CONSTS_VH
`define FST_CONSTS_VH

`define FST_A_PAGE 8'h00
`define FST_A_MODE 8'h02
`define FST_A_PD 8'h38
`define FST_A_MASK0 8'h3B
`define FST_A_MASK1 8'h3C
`define FST_A_MASK4 8'h3D
`define FST_A_MASK2 8'h40
`define FST_A_MASK3 8'h41
`define FST_A_LIVE0 8'h42
`define FST_A_LIVE1 8'h43
`define FST_A_LIVE1_0 8'h44
`define FST_A_LIVE2 8'h47
`define FST_A_LIVE3 8'h48
`define FST_A_LTCH0 8'h49
`define FST_A_LTCH1 8'h4A
`define FST_A_LTCH1_0 8'h4B
`define FST_A_LTCH2 8'h4F
`define FST_A_LTCH3 8'h50
`define FST_A_LTCH4 8'h51
`define FST_A_CLKCFG 8'h5C
`define FST_A_STATCFG 8'h16
`define FST_A_SFC0 8'h08
`define FST_A_SFC1 8'h09
`define FST_A_SFC2 8'h0A
`define FST_A_SFC3 8'h0C
`define FST_A_SFC4 8'h0D
`define FST_A_SFC5 8'h0E
`define FST_A_SFC6 8'h0F
`define FST_A_SFC7 8'h10
`define FST_A_SFC8 8'h11
`define FST_A_SFC9 8'h12
`define FST_A_SFC10 8'h13
`define FST_A_SFC11 8'h14

`define FST_STAT_EN_BIT 6
`define FST_LTCH_CLR_BIT 2
`define FST_SLOT_BITS 32
`define FST_WORD_BITS 8
`define FST_WORD_END 11'd8
`define FST_MASK2_RST 8'h0F
`define FST_MASK0_RST 8'h00

`define FST_TEMP_TH0 8'd105
`define FST_TEMP_TH1 8'd115
`define FST_TEMP_TH2 8'd125
`define FST_TEMP_TH3 8'd135

`endif

// file: hdl/fst_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fst_consts.vh"

module fst_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module fst_top (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // TDM link
  input wire tdm_bclk,
  input wire tdm_fsync,
  output reg tdm_dout_q,
  output reg tdm_dout_oe_n_q,
  // Device state
  input wire hardware_shutdown_pin_n,
  input wire active_mode,
  input wire shutdown_transient,
  input wire shutdown_done,
  input wire powered_up,
  input wire low_voltage_supply_sel,
  input wire noise_gate_active,
  input wire limiter_atten,
  input wire brownout_prevention_atten,
  input wire over_temp,
  input wire over_current,
  input wire high_voltage_supply_uvlo,
  input wire [7:0] die_temp_c,
  // Pins
  output reg interrupt_output_pin_q,
  output reg interrupt_output_pin_oe_n_q,
  output reg [4:0] input_pulldown_enable_q
);
  // Synchronisers for pins
  reg [1:0] bclk_s_q;
  reg [1:0] fs_s_q;
  reg [1:0] sdz_s_q;
  reg bclk_d1_q;
  reg fs_d1_q;
  wire bclk_rise;
  wire bclk_fall;
  wire hw_shutdown;

  always @(posedge clk) begin
    if (rst) begin
      bclk_s_q <= 2'b00;
      fs_s_q <= 2'b00;
      sdz_s_q <= 2'b00;
      bclk_d1_q <= 1'b0;
      fs_d1_q <= 1'b0;
    end else begin
      bclk_s_q <= {bclk_s_q[0], tdm_bclk};
      fs_s_q <= {fs_s_q[0], tdm_fsync};
      sdz_s_q <= {sdz_s_q[0], hardware_shutdown_pin_n};
      bclk_d1_q <= bclk_s_q[1];
      if (bclk_rise) begin
        fs_d1_q <= fs_s_q[1];
      end
    end
  end

  assign bclk_rise = bclk_s_q[1] && !bclk_d1_q;
  assign bclk_fall = !bclk_s_q[1] && bclk_d1_q;
  assign hw_shutdown = !sdz_s_q[1];

  // Registers
  reg [7:0] page_q;
  reg [7:0] mode_q;
  reg [7:0] pd_q;
  reg [7:0] mask0_q;
  reg [7:0] mask1_q;
  reg [7:0] mask2_q;
  reg [7:0] mask3_q;
  reg [7:0] mask4_q;
  reg [7:0] clkcfg_q;
  reg [7:0] statcfg_q;
  reg [7:0] live0_q, live2_q, ltch0_q, ltch2_q;
  reg [7:0] tcfg_q [0:11];
  reg [3:0] tidx;
  reg tsel;
  reg [7:0] rd_d;
  wire pg0;
  wire wr0;
  wire ltch_clr;
  wire status_en;
  wire [5:0] status_slot;
  wire [3:0] temp_hit;
  wire [2:0] fault_now;

  assign pg0 = (page_q == 8'h00);
  assign wr0 = reg_wr && pg0;
  assign ltch_clr = wr0 && (reg_addr == `FST_A_CLKCFG) &&
                    reg_wdata[`FST_LTCH_CLR_BIT];
  assign status_en = statcfg_q[`FST_STAT_EN_BIT];
  assign status_slot = statcfg_q[5:0];

  // Temperature comparators, one per threshold
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_temp
      wire [7:0] th;
      assign th = (gi == 0) ? `FST_TEMP_TH0 :
                  (gi == 1) ? `FST_TEMP_TH1 :
                  (gi == 2) ? `FST_TEMP_TH2 : `FST_TEMP_TH3;
      assign temp_hit[gi] = (die_temp_c > th);
    end
  endgenerate

  assign fault_now = {high_voltage_supply_uvlo, over_current, over_temp};

  // Index of serial frame config registers
  always @* begin
    tsel = 1'b1;
    tidx = 4'd0;
    case (reg_addr)
      `FST_A_SFC0: tidx = 4'd0;
      `FST_A_SFC1: tidx = 4'd1;
      `FST_A_SFC2: tidx = 4'd2;
      `FST_A_SFC3: tidx = 4'd3;
      `FST_A_SFC4: tidx = 4'd4;
      `FST_A_SFC5: tidx = 4'd5;
      `FST_A_SFC6: tidx = 4'd6;
      `FST_A_SFC7: tidx = 4'd7;
      `FST_A_SFC8: tidx = 4'd8;
      `FST_A_SFC9: tidx = 4'd9;
      `FST_A_SFC10: tidx = 4'd10;
      `FST_A_SFC11: tidx = 4'd11;
      default: tsel = 1'b0;
    endcase
  end

  integer i;
  always @(posedge clk) begin
    if (rst) begin
      page_q <= 8'h00;
      mode_q <= 8'h00;
      pd_q <= 8'h00;
      mask0_q <= `FST_MASK0_RST;
      mask1_q <= 8'h00;
      mask2_q <= `FST_MASK2_RST;
      mask3_q <= 8'h00;
      mask4_q <= 8'h00;
      clkcfg_q <= 8'h00;
      statcfg_q <= 8'h00;
      for (i = 0; i < 12; i = i + 1) begin
        tcfg_q[i] <= 8'h00;
      end
    end else if (reg_wr) begin
      if (reg_addr == `FST_A_PAGE) begin
        page_q <= reg_wdata;
      end else if (pg0) begin
        if (tsel) begin
          tcfg_q[tidx] <= reg_wdata;
        end
        case (reg_addr)
          `FST_A_MODE: mode_q <= reg_wdata;
          `FST_A_PD: pd_q <= {3'b000, reg_wdata[4:0]};
          `FST_A_MASK0: mask0_q <= reg_wdata;
          `FST_A_MASK1: mask1_q <= reg_wdata;
          `FST_A_MASK4: mask4_q <= reg_wdata;
          `FST_A_MASK2: mask2_q <= reg_wdata;
          `FST_A_MASK3: mask3_q <= reg_wdata;
          `FST_A_CLKCFG: begin
            clkcfg_q <= reg_wdata & ~(8'h01 << `FST_LTCH_CLR_BIT);
          end
          `FST_A_STATCFG: statcfg_q <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Live and latched flags
  always @(posedge clk) begin
    if (rst) begin
      live0_q <= 8'h00;
      live2_q <= 8'h00;
      ltch0_q <= 8'h00;
      ltch2_q <= 8'h00;
    end else begin
      if (!active_mode || hw_shutdown) begin
        live0_q <= 8'h00;
        live2_q <= 8'h00;
      end else begin
        live0_q <= {5'b00000, fault_now};
        live2_q <= {4'h0, temp_hit};
      end
      // Set wins over clear; shutdown does not touch them
      ltch0_q <= (ltch_clr ? 8'h00 : ltch0_q) |
                 {5'b00000, fault_now};
      ltch2_q <= (ltch_clr ? 8'h00 : ltch2_q) |
                 {4'h0, temp_hit & {4{active_mode}}};
    end
  end

  // Read data
  always @* begin
    rd_d = 8'h00;
    if (reg_addr == `FST_A_PAGE) begin
      rd_d = page_q;
    end else if (pg0) begin
      if (tsel) begin
        rd_d = tcfg_q[tidx];
      end
      case (reg_addr)
        `FST_A_MODE: rd_d = mode_q;
        `FST_A_PD: rd_d = pd_q;
        `FST_A_MASK0: rd_d = mask0_q;
        `FST_A_MASK1: rd_d = mask1_q;
        `FST_A_MASK4: rd_d = mask4_q;
        `FST_A_MASK2: rd_d = mask2_q;
        `FST_A_MASK3: rd_d = mask3_q;
        `FST_A_LIVE0: rd_d = live0_q;
        `FST_A_LIVE2: rd_d = live2_q;
        `FST_A_LIVE1, `FST_A_LIVE1_0, `FST_A_LIVE3: rd_d = 8'h00;
        `FST_A_LTCH0: rd_d = ltch0_q;
        `FST_A_LTCH2: rd_d = ltch2_q;
        `FST_A_LTCH1, `FST_A_LTCH1_0, `FST_A_LTCH3, `FST_A_LTCH4: rd_d = 8'h00;
        `FST_A_CLKCFG: rd_d = clkcfg_q;
        `FST_A_STATCFG: rd_d = statcfg_q;
        default: ;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_d;
    end
  end

  // Interrupt pin and pull-downs
  always @(posedge clk) begin
    if (rst) begin
      interrupt_output_pin_q <= 1'b0;
      interrupt_output_pin_oe_n_q <= 1'b1;
      input_pulldown_enable_q <= 5'b00000;
    end else begin
      interrupt_output_pin_q <= 1'b0;
      interrupt_output_pin_oe_n_q <=
        !(|(ltch0_q[2:0] & ~mask0_q[2:0]) ||
          |(ltch2_q[3:0] & ~mask2_q[3:0]));
      input_pulldown_enable_q <= hw_shutdown ? 5'b00000 : pd_q[4:0];
    end
  end

  // Status word and its queue
  wire [7:0] status_word;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg fifo_push;
  reg fifo_pop;
  reg [10:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg sending_q;
  reg pop_req_q;
  reg [10:0] word_base_q;
  wire pop_hit;
  wire [10:0] slot_base;
  wire frame_start;
  wire tx_ok;

  assign status_word = {high_voltage_supply_uvlo & shutdown_transient,
                        over_current & shutdown_transient,
                        over_temp & shutdown_transient,
                        brownout_prevention_atten, limiter_atten,
                        noise_gate_active, low_voltage_supply_sel,
                        powered_up};
  assign tx_ok = status_en && !shutdown_done && !hw_shutdown;
  assign slot_base = {status_slot, 5'b00000};
  assign frame_start = bclk_rise && fs_s_q[1] && !fs_d1_q;
  assign pop_hit = bclk_rise && tx_ok &&
                   ((frame_start ? 11'd0 : bit_cnt_q + 11'd1) == slot_base);

  always @* begin
    fifo_push = frame_start && tx_ok;
    // Stale word left by a cut frame is dropped at the next frame start
    fifo_pop = (frame_start && fifo_out_valid) || (pop_req_q && tx_ok);
  end

  fst_fifo #(
    .WIDTH(`FST_WORD_BITS),
    .DEPTH(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_data(status_word),
    .in_ready(),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  // Slot counter on bit clock rising edges, drive on falling edges
  always @(posedge clk) begin
    if (rst) begin
      bit_cnt_q <= 11'd0;
      shift_q <= 8'h00;
      sending_q <= 1'b0;
      pop_req_q <= 1'b0;
      word_base_q <= 11'd0;
      tdm_dout_q <= 1'b0;
      tdm_dout_oe_n_q <= 1'b1;
    end else begin
      if (bclk_rise) begin
        bit_cnt_q <= frame_start ? 11'd0 : bit_cnt_q + 11'd1;
      end
      pop_req_q <= pop_hit;
      if (pop_hit) begin
        word_base_q <= slot_base;
      end
      if (pop_req_q && fifo_out_valid) begin
        shift_q <= fifo_out_data;
        sending_q <= 1'b1;
      end else if (bclk_rise && bit_cnt_q + 11'd1 ==
                   word_base_q + `FST_WORD_END) begin
        sending_q <= 1'b0;
      end
      if (!tx_ok) begin
        sending_q <= 1'b0;
        tdm_dout_oe_n_q <= 1'b1;
        tdm_dout_q <= 1'b0;
      end else if (bclk_fall) begin
        if (sending_q && bit_cnt_q >= word_base_q &&
            bit_cnt_q < word_base_q + `FST_WORD_END) begin
          tdm_dout_q <= shift_q[7];
          shift_q <= {shift_q[6:0], 1'b0};
          tdm_dout_oe_n_q <= 1'b0;
        end else begin
          tdm_dout_q <= 1'b0;
          tdm_dout_oe_n_q <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: verif/fst_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fst_top_monitor (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  // Link and pins
  input wire tdm_dout_oe_n_q,
  input wire hardware_shutdown_pin_n,
  input wire active_mode,
  input wire shutdown_done,
  input wire [7:0] die_temp_c,
  input wire interrupt_output_pin_q,
  input wire [4:0] input_pulldown_enable_q
);
  logic [7:0] page_q, stat_q, pd_q, low_q;
  logic clr_p_q, clr_q;
  wire wr0 = reg_wr && page_q == 8'h00;
  wire rd0 = reg_rd && page_q == 8'h00;
  wire [3:0] th = {die_temp_c > 8'h87, die_temp_c > 8'h7d,
    die_temp_c > 8'h73, die_temp_c > 8'h69};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mirror of the host's configuration writes
  always @(posedge clk) begin
    if (rst) begin
      page_q <= 8'h00;
      stat_q <= 8'h00;
      pd_q <= 8'h00;
      clr_p_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) page_q <= reg_wdata;
      if (wr0 && reg_addr == 8'h16) stat_q <= reg_wdata;
      if (wr0 && reg_addr == 8'h38) pd_q <= reg_wdata;
      clr_p_q <= wr0 && reg_addr == 8'h5c && reg_wdata[2];
      clr_q <= !active_mode && (clr_p_q || clr_q);
    end
  end
  // Length of the driven stretch of the data line
  always @(posedge clk) begin
    if (tdm_dout_oe_n_q) low_q <= 8'h00;
    else low_q <= low_q + 8'h01;
  end
  property p_rd_cfg;
    rd0 && reg_addr == 8'h16 |=> reg_rdata_q == stat_q;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("status config readback wrong");
  property p_pd;
    (hardware_shutdown_pin_n && !(wr0 && reg_addr == 8'h38))[*5]
      |-> input_pulldown_enable_q == pd_q[4:0];
  endproperty
  a_pd: assert property (p_pd)
    else $error("pull-down enables differ from field");
  property p_pd_off;
    (!hardware_shutdown_pin_n)[*5] |-> input_pulldown_enable_q == 5'h00;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("pull-down on in shutdown");
  property p_tx_en;
    (!stat_q[6])[*3] |-> tdm_dout_oe_n_q;
  endproperty
  a_tx_en: assert property (p_tx_en)
    else $error("data line driven with transmit off");
  property p_oe_len;
    $rose(tdm_dout_oe_n_q) && stat_q[6] && hardware_shutdown_pin_n
      && !shutdown_done |-> low_q >= 8'h7e && low_q <= 8'h82;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("status word not eight bit periods");
  property p_irq_pin;
    interrupt_output_pin_q == 1'b0;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin driven high");
  property p_clr;
    rd0 && reg_addr == 8'h4f && clr_q |=> reg_rdata_q == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("latched flags survive clear");
  property p_live;
    (!active_mode)[*3] ##0 (rd0 && reg_addr == 8'h47)
      |=> reg_rdata_q == 8'h00;
  endproperty
  a_live: assert property (p_live)
    else $error("live flags set while stopped");
  property p_temp;
    (active_mode && $stable(die_temp_c))[*3] ##0 (rd0 && reg_addr == 8'h47)
      |=> reg_rdata_q[3:0] == $past(th);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature warnings wrong");
endmodule
bind fst_top fst_top_monitor fst_top_monitor_i (.clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .tdm_dout_oe_n_q,
  .hardware_shutdown_pin_n, .active_mode, .shutdown_done, .die_temp_c,
  .interrupt_output_pin_q, .input_pulldown_enable_q);
`default_nettype wire

// file: verif/fst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fst_host_model (
  // Control
  input wire logic run,
  // Link
  output logic tdm_bclk,
  output logic tdm_fsync,
  input wire logic tdm_dout_q,
  input wire logic tdm_dout_oe_n_q,
  // Capture
  output logic [7:0] word_q,
  output logic [7:0] first_q,
  output logic [15:0] bits_q
);
  logic [5:0] pos_q;
  logic prev_q;
  initial begin
    tdm_bclk = 1'b0;
    tdm_fsync = 1'b0;
    pos_q = 6'h3e;
    prev_q = 1'b1;
    word_q = 8'h00;
    first_q = 8'h00;
    bits_q = 16'h0000;
  end
  // Bit clock of 160 ns, parked low between runs
  always begin
    #80;
    if (run || tdm_bclk) tdm_bclk = ~tdm_bclk;
  end
  // Frames of two 32-bit slots
  always @(negedge tdm_bclk) tdm_fsync <= (pos_q == 6'h3f);
  // Sample the line only while the device drives it
  always @(posedge tdm_bclk) begin
    pos_q <= pos_q + 6'h01;
    prev_q <= tdm_dout_oe_n_q;
    if (!tdm_dout_oe_n_q) begin
      word_q <= {word_q[6:0], tdm_dout_q};
      bits_q <= bits_q + 16'h0001;
      if (prev_q) first_q <= {2'h0, pos_q};
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_fst_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_fst_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] die_temp_c = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic hw_n = 1'b1;
  logic run = 1'b0;
  // uvlo oc ot bop lim gate lowv pwr done trans active
  logic [10:0] st = 11'h000;
  logic [15:0] n;
  int error_cnt = 0;
  int samples_checked = 0;
  wire tdm_bclk, tdm_fsync, tdm_dout_q, tdm_dout_oe_n_q, irq, irq_oe_n;
  wire [7:0] rdata, word, first;
  wire [4:0] pd;
  wire [15:0] bits;
  fst_top fst_top_i (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q(rdata), .tdm_bclk, .tdm_fsync, .tdm_dout_q,
    .tdm_dout_oe_n_q, .hardware_shutdown_pin_n(hw_n),
    .active_mode(st[0]), .shutdown_transient(st[1]),
    .shutdown_done(st[2]), .powered_up(st[3]),
    .low_voltage_supply_sel(st[4]), .noise_gate_active(st[5]),
    .limiter_atten(st[6]), .brownout_prevention_atten(st[7]),
    .over_temp(st[8]), .over_current(st[9]),
    .high_voltage_supply_uvlo(st[10]), .die_temp_c,
    .interrupt_output_pin_q(irq), .interrupt_output_pin_oe_n_q(irq_oe_n),
    .input_pulldown_enable_q(pd));
  fst_host_model fst_host_model_i (.run, .tdm_bclk, .tdm_fsync,
    .tdm_dout_q, .tdm_dout_oe_n_q, .word_q(word), .first_q(first),
    .bits_q(bits));
  always #5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    `CHK("register read", e, rdata)
  endtask
  task automatic frame_chk(input logic [7:0] s);
    repeat (3072) @(posedge clk);
    `CHK("status word", st[10:3] & (st[1] ? 8'hff : 8'h1f), word)
    `CHK("slot start", s * 8'h20, first)
  endtask
  task automatic quiet_chk;
    repeat (1024) @(posedge clk);
    n = bits;
    repeat (2048) @(posedge clk);
    `CHK("bits sent", n, bits)
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h3b, 8'h00);
    rd(8'h40, 8'h0f);
    rd(8'h01, 8'h00);
    wr(8'h38, 8'h15);
    rd(8'h38, 8'h15);
    `CHK("pull-downs", 5'h15, pd)
    hw_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("pull-downs", 5'h00, pd)
    hw_n <= 1'b1;
    wr(8'h00, 8'h01);
    rd(8'h38, 8'h00);
    wr(8'h00, 8'h00);
    st <= 11'h001;
    for (int i = 0; i < 5; i++) begin
      die_temp_c <= 8'h69 + 8'(i * 10);
      repeat (4) @(posedge clk);
      rd(8'h47, 8'((1 << i) - 1));
    end
    `CHK("irq enable", 1'b1, irq_oe_n)
    wr(8'h40, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq enable", 1'b0, irq_oe_n)
    st <= 11'h000;
    rd(8'h47, 8'h00);
    rd(8'h4f, 8'h0f);
    wr(8'h5c, 8'h04);
    rd(8'h4f, 8'h00);
    rd(8'h5c, 8'h00);
    `CHK("irq enable", 1'b1, irq_oe_n)
    st <= 11'h201;
    repeat (3) @(posedge clk);
    st <= 11'h000;
    rd(8'h49, 8'h02);
    wr(8'h5c, 8'h04);
    rd(8'h49, 8'h00);
    run <= 1'b1;
    st <= 11'h1a9;
    for (int s = 0; s < 2; s++) begin
      wr(8'h16, 8'h40 | 8'(s));
      frame_chk(8'(s));
    end
    st <= 11'h7ab;
    frame_chk(8'h01);
    st <= 11'h7af;
    quiet_chk;
    wr(8'h16, 8'h01);
    st <= 11'h1a9;
    quiet_chk;
    wr(8'h16, 8'h40);
    hw_n <= 1'b0;
    quiet_chk;
    give_verdict;
  end
endmodule
`default_nettype wire
